// ===== core/tgas_defs.vh
// Constants for the tributary group adaptation sink
`ifndef TGAS_DEFS_VH
`define TGAS_DEFS_VH
// Path frame layout, in bytes
`define TGAS_FRAME_LEN 9'h1F9
`define TGAS_NUM_SLOTS 4'hE
`define TGAS_ROWS 6'h24
`define TGAS_LAST_SLOT 4'hD
`define TGAS_LAST_ROW 6'h23
// Overhead label byte field positions, bit 7 is the MSB
`define TGAS_LABEL_HI 5
`define TGAS_LABEL_LO 3
`define TGAS_MFI_HI 2
`define TGAS_MFI_LO 1
`define TGAS_LABEL_TU12 3'h3
`define TGAS_LABEL_ACCEPT 3'h5
`define TGAS_MF_GOOD 3'h4
// Pointer byte fields
`define TGAS_NDF_NORMAL 4'h6
`define TGAS_NDF_SET 4'h9
`define TGAS_SS_TU12 2'h2
`define TGAS_PTR_MAX 10'h08B
`define TGAS_PTR_ACCEPT 2'h3
`define TGAS_AIS_ACCEPT 2'h3
`define TGAS_LOP_COUNT 4'h8
`define TGAS_ROW_BYTES 8'h23
// Multiframe loss time: 3 ms counted in 100 MHz clock cycles
`define TGAS_LOM_CYCLES 19'h4_93E0
`endif

// ===== core/tgas_sink.v
// Tributary group adaptation sink: label, multiframe and pointer sinks
`include "tgas_defs.vh"

// Operation
// R1: Accepted three-bit structure label is compared with TU-12 code 011.
// R2: Multiframe phase recovered from two indicator bits in successive frames.
// R3: A single indicator sequence error sends the aligner out of multiframe.
// R4: In-multiframe entered after four consecutive error-free frames.
// R5: Inactive label part forces server fail and suppresses its reports.
// R6: Label mismatch defect whenever accepted label differs from 011.
// R7: Out of multiframe for fixed 3 ms declares multiframe loss defect.
// R8: Multiframe loss defect clears on re-entering in-multiframe state.
// R9: Server fail raised on label mismatch or multiframe loss defect.
// R10: Label mismatch fault is the defect gated by incoming trail fail.
// R11: Multiframe loss fault needs defect, no trail fail, no mismatch.
// R12: VC-12 sink interprets TU-12 pointer, delivers data and frame phase.
// R13: VC-11 sink interprets TU-12 pointer, delivers data and frame phase.
// R14: Each sink works on one timeslot chosen by a parameter 0 to 13.
// R15: Management deactivates sinks not matching the configured structure.
// R16: Inactive sink outputs all-ones and suppresses its reports.
// R17: Each sink detects pointer alarm and pointer loss defects.
// R18: Alarm, pointer loss or trail fail raise all-ones and server fail.
// R19: All-ones appears and clears within 1 ms of the request changing.
// R20: Alarm fault needs defect, no trail fail, reporting option on.
// R21: Pointer loss fault is the defect gated by trail fail.
// R22: Alarm reporting option is off after reset.
// R23: Termination passes data through; server fail becomes trail fail.
module tgas_sink #(
  parameter [3:0] VC12_SLOT = 4'h0,
  parameter [3:0] VC11_SLOT = 4'h1,
  parameter [18:0] LOM_CYCLES = `TGAS_LOM_CYCLES
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Path layer link
  input wire path_clk,
  input wire [7:0] path_data,
  input wire path_frame_start,
  input wire incoming_trail_fail,
  // Management of the label part
  input wire function_activation,
  output wire label_mismatch_fault,
  output wire multiframe_loss_fault,
  // Tributary group stream
  output reg [7:0] tg_data,
  output reg tg_valid,
  output reg tg_frame_start,
  output reg tg_multiframe_start,
  output wire server_fail_request,
  output wire trail_fail_request,
  // Tributary sinks, index 0 is VC-12, index 1 is VC-11
  input wire [1:0] sink_activation,
  input wire [1:0] alarm_report_option,
  output wire [15:0] vc_data,
  output wire [1:0] vc_valid,
  output wire [1:0] vc_frame_start,
  output wire [1:0] vc_server_fail,
  output wire [1:0] pointer_alarm_fault,
  output wire [1:0] pointer_loss_fault
);

  function [9:0] tgas_row_base;
    input [1:0] phase;
    begin
      tgas_row_base = {2'b00, `TGAS_ROW_BYTES} * {8'h00, phase};
    end
  endfunction

  // Link input synchronisers
  reg [2:0] clk_sync_q;
  reg [7:0] data_s1_q, data_s2_q;
  reg fs_s1_q, fs_s2_q;
  wire byte_stb = clk_sync_q[1] & ~clk_sync_q[2];

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clk_sync_q <= 3'h0;
      data_s1_q <= 8'h00;
      data_s2_q <= 8'h00;
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], path_clk};
      data_s1_q <= path_data;
      data_s2_q <= data_s1_q;
      fs_s1_q <= path_frame_start;
      fs_s2_q <= fs_s1_q;
    end
  end

  // Frame position: overhead byte, then rows of fourteen slot bytes
  reg oh_pos_q;
  reg [3:0] slot_q;
  reg [5:0] row_q;
  wire oh_byte = byte_stb & (fs_s2_q | oh_pos_q);
  wire pay_byte = byte_stb & ~oh_byte;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      oh_pos_q <= 1'b0;
      slot_q <= 4'h0;
      row_q <= 6'h00;
    end else if (oh_byte) begin
      oh_pos_q <= 1'b0;
      slot_q <= 4'h0;
      row_q <= 6'h00;
    end else if (pay_byte) begin
      if (slot_q == `TGAS_LAST_SLOT) begin
        slot_q <= 4'h0;
        if (row_q == `TGAS_LAST_ROW) begin
          row_q <= 6'h00;
          oh_pos_q <= 1'b1;
        end else begin
          row_q <= row_q + 6'h01;
        end
      end else begin
        slot_q <= slot_q + 4'h1;
      end
    end
  end

  // Label acceptance and multiframe alignment
  wire [2:0] rx_label = data_s2_q[`TGAS_LABEL_HI:`TGAS_LABEL_LO];
  wire [1:0] rx_mfi = data_s2_q[`TGAS_MFI_HI:`TGAS_MFI_LO];
  reg [2:0] lbl_cand_q, lbl_acc_q, lbl_cnt_q;
  reg [1:0] mf_phase_q;
  reg mf_in_q;
  reg [2:0] mf_good_q;
  reg [18:0] lom_cnt_q;
  reg lom_q;
  wire mf_next_ok = (rx_mfi == mf_phase_q + 2'h1);
  wire plm = (lbl_acc_q != `TGAS_LABEL_TU12); // R1 R6

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lbl_cand_q <= `TGAS_LABEL_TU12;
      lbl_acc_q <= `TGAS_LABEL_TU12;
      lbl_cnt_q <= 3'h0;
      mf_phase_q <= 2'h0;
      mf_in_q <= 1'b0;
      mf_good_q <= 3'h0;
    end else if (oh_byte) begin
      if (rx_label != lbl_cand_q) begin
        lbl_cand_q <= rx_label;
        lbl_cnt_q <= 3'h1;
      end else if (lbl_cnt_q == `TGAS_LABEL_ACCEPT - 3'h1) begin
        lbl_acc_q <= lbl_cand_q;
        lbl_cnt_q <= `TGAS_LABEL_ACCEPT;
      end else if (lbl_cnt_q != `TGAS_LABEL_ACCEPT) begin
        lbl_cnt_q <= lbl_cnt_q + 3'h1;
      end
      mf_phase_q <= rx_mfi; // R2
      if (mf_in_q) begin
        if (!mf_next_ok) begin
          mf_in_q <= 1'b0; // R3
          mf_good_q <= 3'h0;
        end
      end else if (mf_next_ok) begin
        if (mf_good_q == `TGAS_MF_GOOD - 3'h1) begin
          mf_in_q <= 1'b1; // R4
          mf_good_q <= 3'h0;
        end else begin
          mf_good_q <= mf_good_q + 3'h1;
        end
      end else begin
        mf_good_q <= 3'h0;
      end
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lom_cnt_q <= 19'h0_0000;
      lom_q <= 1'b0;
    end else if (mf_in_q) begin
      lom_cnt_q <= 19'h0_0000;
      lom_q <= 1'b0; // R8
    end else if (lom_cnt_q >= LOM_CYCLES - 19'h0_0001) begin
      lom_q <= 1'b1; // R7
    end else begin
      lom_cnt_q <= lom_cnt_q + 19'h0_0001;
    end
  end

  assign server_fail_request = ~function_activation | plm | lom_q; // R5 R9
  assign label_mismatch_fault = function_activation & plm &
    ~incoming_trail_fail; // R5 R10
  assign multiframe_loss_fault = function_activation & lom_q &
    ~incoming_trail_fail & ~plm; // R5 R11
  assign trail_fail_request = server_fail_request | incoming_trail_fail; // R23

  // Pass-through toward the tributary group
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tg_data <= 8'h00;
      tg_valid <= 1'b0;
      tg_frame_start <= 1'b0;
      tg_multiframe_start <= 1'b0;
    end else begin
      tg_data <= data_s2_q; // R23
      tg_valid <= byte_stb;
      tg_frame_start <= oh_byte;
      tg_multiframe_start <= oh_byte & mf_in_q & (rx_mfi == 2'h0);
    end
  end

  // Per-timeslot pointer interpreting sinks
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sink
      wire [3:0] slot = (gi == 0) ? VC12_SLOT : VC11_SLOT; // R14
      wire mine = pay_byte & (slot_q == slot);
      wire ptr_byte = mine & (row_q == 6'h00);
      wire load_byte = mine & (row_q != 6'h00);
      wire [9:0] pos = tgas_row_base(mf_phase_q) + {4'h0, row_q} - 10'h001;
      reg [7:0] ptr_one_q;
      reg [9:0] ptr_q, cand_q;
      reg [1:0] ok_cnt_q, ais_cnt_q;
      reg [3:0] inv_cnt_q;
      reg ais_q, lop_q, opt_q;
      reg [7:0] out_q;
      reg val_q, vfs_q;
      wire [9:0] rx_ptr = {ptr_one_q[1:0], data_s2_q};
      wire rx_ais = (ptr_one_q == 8'hFF) & (data_s2_q == 8'hFF);
      wire ss_ok = (ptr_one_q[3:2] == `TGAS_SS_TU12) &
        (rx_ptr <= `TGAS_PTR_MAX);
      wire rx_norm = ss_ok & (ptr_one_q[7:4] == `TGAS_NDF_NORMAL);
      wire rx_ndf = ss_ok & (ptr_one_q[7:4] == `TGAS_NDF_SET);
      wire eval = ptr_byte & mf_in_q & (mf_phase_q == 2'h1);
      wire tsf = trail_fail_request;
      wire ones = ais_q | lop_q | tsf | ~sink_activation[gi]; // R16 R18

      always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          ptr_one_q <= 8'h00;
          ptr_q <= 10'h000;
          cand_q <= 10'h000;
          ok_cnt_q <= 2'h0;
          ais_cnt_q <= 2'h0;
          inv_cnt_q <= 4'h0;
          ais_q <= 1'b0;
          lop_q <= 1'b0;
        end else begin
          if (ptr_byte && mf_phase_q == 2'h0)
            ptr_one_q <= data_s2_q;
          if (eval) begin
            if (rx_ais) begin
              inv_cnt_q <= 4'h0;
              ok_cnt_q <= 2'h0;
              if (ais_cnt_q == `TGAS_AIS_ACCEPT - 2'h1) begin
                ais_q <= 1'b1; // R17
                lop_q <= 1'b0;
              end else begin
                ais_cnt_q <= ais_cnt_q + 2'h1;
              end
            end else if (rx_ndf) begin
              ais_cnt_q <= 2'h0;
              inv_cnt_q <= 4'h0;
              ptr_q <= rx_ptr; // R12 R13
              cand_q <= rx_ptr;
              ok_cnt_q <= 2'h0;
              ais_q <= 1'b0;
              lop_q <= 1'b0;
            end else if (rx_norm) begin
              ais_cnt_q <= 2'h0;
              inv_cnt_q <= 4'h0;
              if (rx_ptr != cand_q) begin
                cand_q <= rx_ptr;
                ok_cnt_q <= 2'h1;
              end else if (ok_cnt_q == `TGAS_PTR_ACCEPT - 2'h1) begin
                ptr_q <= cand_q; // R12 R13
                ais_q <= 1'b0;
                lop_q <= 1'b0;
              end else begin
                ok_cnt_q <= ok_cnt_q + 2'h1;
              end
            end else begin
              ais_cnt_q <= 2'h0;
              ok_cnt_q <= 2'h0;
              if (inv_cnt_q == `TGAS_LOP_COUNT - 4'h1) begin
                lop_q <= 1'b1; // R17
                ais_q <= 1'b0;
              end else begin
                inv_cnt_q <= inv_cnt_q + 4'h1;
              end
            end
          end
        end
      end

      always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          out_q <= 8'hFF;
          val_q <= 1'b0;
          vfs_q <= 1'b0;
          opt_q <= 1'b0; // R22
        end else begin
          opt_q <= alarm_report_option[gi];
          val_q <= load_byte;
          if (load_byte) begin
            out_q <= ones ? 8'hFF : data_s2_q; // R16 R19
            vfs_q <= (pos == ptr_q) & ~ones; // R12 R13
          end else begin
            vfs_q <= 1'b0;
          end
        end
      end

      assign vc_data[gi*8+7:gi*8] = out_q;
      assign vc_valid[gi] = val_q;
      assign vc_frame_start[gi] = vfs_q;
      assign vc_server_fail[gi] = ais_q | lop_q | tsf; // R18
      assign pointer_alarm_fault[gi] = sink_activation[gi] & ais_q &
        ~tsf & opt_q; // R16 R20
      assign pointer_loss_fault[gi] = sink_activation[gi] & lop_q &
        ~tsf; // R16 R21
    end
  endgenerate

endmodule // tgas_sink

// ===== dv/tgas_checker.sv
// Port assertions for the tributary group sink
module tgas_checker (
  // Clock
  input logic core_clk,
  input logic resetn,
  // Inputs
  input logic [7:0] path_data,
  input logic incoming_trail_fail,
  input logic function_activation,
  input logic [1:0] alarm_report_option,
  // Outputs
  input logic label_mismatch_fault,
  input logic multiframe_loss_fault,
  input logic [7:0] tg_data,
  input logic tg_valid,
  input logic tg_frame_start,
  input logic tg_multiframe_start,
  input logic server_fail_request,
  input logic trail_fail_request,
  input logic [1:0] vc_valid,
  input logic [1:0] vc_frame_start,
  input logic [1:0] vc_server_fail,
  input logic [1:0] pointer_alarm_fault,
  input logic [1:0] pointer_loss_fault
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_act_ssf: assert property (
    !function_activation |-> server_fail_request
    && !label_mismatch_fault && !multiframe_loss_fault)
    else $error("inactive label part not failing");
  chk_trail_or: assert property (
    trail_fail_request == (server_fail_request | incoming_trail_fail))
    else $error("trail fail mismatch");
  chk_fault_gate: assert property (
    incoming_trail_fail |-> !label_mismatch_fault && !multiframe_loss_fault
    && pointer_loss_fault == 2'h0 && pointer_alarm_fault == 2'h0)
    else $error("fault not gated by trail fail");
  chk_defect_ssf: assert property (
    label_mismatch_fault || multiframe_loss_fault |-> server_fail_request)
    else $error("server fail missing");
  chk_lom_plm: assert property (
    multiframe_loss_fault |-> !label_mismatch_fault)
    else $error("loss fault with mismatch");
  chk_vc_ssf: assert property (
    incoming_trail_fail |-> vc_server_fail == 2'h3)
    else $error("sink server fail missing");
  chk_ais_opt: assert property (
    (pointer_alarm_fault & ~$past(alarm_report_option)) == 2'h0)
    else $error("alarm fault without option");
  chk_tg_byte: assert property (
    tg_valid |-> tg_data == $past(path_data, 3) ##1 !tg_valid [*2])
    else $error("group byte wrong");
  chk_mf_phase: assert property (
    tg_multiframe_start |-> tg_frame_start && tg_data[2:1] == 2'h0)
    else $error("multiframe start wrong");
  chk_vfs_valid: assert property (
    (vc_frame_start & ~vc_valid) == 2'h0)
    else $error("container start without container byte");
endmodule // tgas_checker
bind tgas_sink tgas_checker tgas_checker_inst (
  .core_clk(core_clk),
  .resetn(resetn),
  .path_data(path_data),
  .incoming_trail_fail(incoming_trail_fail),
  .function_activation(function_activation),
  .alarm_report_option(alarm_report_option),
  .label_mismatch_fault(label_mismatch_fault),
  .multiframe_loss_fault(multiframe_loss_fault),
  .tg_data(tg_data),
  .tg_valid(tg_valid),
  .tg_frame_start(tg_frame_start),
  .tg_multiframe_start(tg_multiframe_start),
  .server_fail_request(server_fail_request),
  .trail_fail_request(trail_fail_request),
  .vc_valid(vc_valid),
  .vc_frame_start(vc_frame_start),
  .vc_server_fail(vc_server_fail),
  .pointer_alarm_fault(pointer_alarm_fault),
  .pointer_loss_fault(pointer_loss_fault)
);

// ===== dv/tgas_framer.sv
// Path framer model sending byte frames
module tgas_framer (
  // Link
  output logic path_clk,
  output logic [7:0] path_data,
  output logic path_frame_start,
  // Controls
  input logic [2:0] label,
  input logic bad_mfi
);
  timeunit 1ns;
  timeprecision 100ps;
  int b = 504;
  int r;
  logic [1:0] ph = 2'h3;
  initial begin
    path_clk = 1'b0;
    path_data = 8'h00;
    path_frame_start = 1'b0;
  end
  always #62.5 path_clk = ~path_clk;
  // Bytes move on the fall so they are stable around the rise
  always @(negedge path_clk) begin
    b = (b == 504) ? 0 : b + 1;
    r = (b - 1) / 14;
    path_frame_start <= (b == 0);
    if (b == 0) begin
      ph = ph + 2'h1;
      path_data <= {2'h0, label, bad_mfi ? ph + 2'h2 : ph, 1'b0};
    end else if (r == 0) begin
      path_data <= (ph == 2'h0) ? 8'h98 : 8'h00;
    end else begin
      path_data <= {4'h1, 4'((b - 1) % 14)};
    end
  end
endmodule // tgas_framer

// ===== dv/tgas_sink_bench.sv
// Self-checking bench for the tributary group sink
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tgas_sink_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic incoming_trail_fail = 1'b0;
  logic function_activation = 1'b1;
  logic [1:0] sink_activation = 2'h3;
  logic [1:0] alarm_report_option = 2'h0;
  logic [2:0] label = 3'h3;
  logic bad_mfi = 1'b0;
  wire path_clk, path_frame_start, tg_valid, tg_frame_start;
  wire label_mismatch_fault, multiframe_loss_fault, tg_multiframe_start;
  wire server_fail_request, trail_fail_request;
  wire [7:0] path_data, tg_data;
  wire [15:0] vc_data;
  wire [1:0] vc_valid, vc_frame_start, vc_server_fail;
  wire [1:0] pointer_alarm_fault, pointer_loss_fault;
  int num_errors = 0;
  int checks = 0;
  always #5 core_clk = ~core_clk;
  tgas_framer tgas_framer_inst (
    .path_clk(path_clk),
    .path_data(path_data),
    .path_frame_start(path_frame_start),
    .label(label),
    .bad_mfi(bad_mfi)
  );
  tgas_sink #(.VC12_SLOT(4'h0), .VC11_SLOT(4'hD), .LOM_CYCLES(19'h0_07D0))
    tgas_sink_inst (
    .core_clk(core_clk),
    .resetn(resetn),
    .path_clk(path_clk),
    .path_data(path_data),
    .path_frame_start(path_frame_start),
    .incoming_trail_fail(incoming_trail_fail),
    .function_activation(function_activation),
    .label_mismatch_fault(label_mismatch_fault),
    .multiframe_loss_fault(multiframe_loss_fault),
    .tg_data(tg_data),
    .tg_valid(tg_valid),
    .tg_frame_start(tg_frame_start),
    .tg_multiframe_start(tg_multiframe_start),
    .server_fail_request(server_fail_request),
    .trail_fail_request(trail_fail_request),
    .sink_activation(sink_activation),
    .alarm_report_option(alarm_report_option),
    .vc_data(vc_data),
    .vc_valid(vc_valid),
    .vc_frame_start(vc_frame_start),
    .vc_server_fail(vc_server_fail),
    .pointer_alarm_fault(pointer_alarm_fault),
    .pointer_loss_fault(pointer_loss_fault)
  );
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge path_frame_start);
    cyc(100);
  endtask
  // First slot byte after a change already sees the new setting; the check reads the second
  task automatic chk_vc(input int i, input logic [7:0] e);
    int n = 0;
    for (int t = 0; t < 2000 && n < 2; t++) begin
      cyc(1);
      if (vc_valid[i] === 1'b1) n++;
    end
    `CHK("vc_data", e, vc_data[8*i +: 8])
  endtask
  task end_of_test;
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    num_errors++;
    end_of_test();
  end
  initial begin
    cyc(20);
    resetn = 1'b1;
    frames(6);
    `CHK("ssf", 1'b0, server_fail_request)
    `CHK("lom", 1'b0, multiframe_loss_fault)
    chk_vc(0, 8'h10);
    chk_vc(1, 8'h1D);
    incoming_trail_fail = 1'b1;
    chk_vc(0, 8'hFF);
    chk_vc(1, 8'hFF);
    `CHK("vc_ssf", 2'h3, vc_server_fail)
    `CHK("tsf", 1'b1, trail_fail_request)
    incoming_trail_fail = 1'b0;
    chk_vc(0, 8'h10);
    sink_activation = 2'h1;
    alarm_report_option = 2'h3;
    chk_vc(1, 8'hFF);
    `CHK("lop", 2'h0, pointer_loss_fault)
    `CHK("ais", 2'h0, pointer_alarm_fault)
    sink_activation = 2'h3;
    frames(1);
    bad_mfi = 1'b1;
    frames(1);
    bad_mfi = 1'b0;
    cyc(2400);
    `CHK("lom", 1'b1, multiframe_loss_fault)
    `CHK("ssf", 1'b1, server_fail_request)
    incoming_trail_fail = 1'b1;
    cyc(1);
    `CHK("lom", 1'b0, multiframe_loss_fault)
    incoming_trail_fail = 1'b0;
    frames(1);
    label = 3'h4;
    frames(2);
    `CHK("ssf", 1'b1, server_fail_request)
    frames(2);
    `CHK("lom", 1'b0, multiframe_loss_fault)
    `CHK("ssf", 1'b0, server_fail_request)
    frames(1);
    `CHK("plm", 1'b1, label_mismatch_fault)
    `CHK("ssf", 1'b1, server_fail_request)
    incoming_trail_fail = 1'b1;
    cyc(1);
    `CHK("plm", 1'b0, label_mismatch_fault)
    incoming_trail_fail = 1'b0;
    function_activation = 1'b0;
    cyc(1);
    `CHK("plm", 1'b0, label_mismatch_fault)
    `CHK("ssf", 1'b1, server_fail_request)
    end_of_test();
  end
endmodule // tgas_sink_bench
